// File: shared/ebw_consts.vh
// Constants for the external byte-bus wait controller.
// Assumes inclusion by bare name from the rtl files; definitions only.
`ifndef EBW_CONSTS_VH
`define EBW_CONSTS_VH

// ==========================================
// Register offsets (byte addresses in the register window)
`define EBW_OFS_CTRL 12'h000
`define EBW_OFS_STAT 12'h004

// ==========================================
// Address decode: haddr bit that selects the external space
`define EBW_EXT_SEL_BIT 16
`define EBW_EXT_AW 16

// ==========================================
// Pause state control register fields
`define EBW_CNT_LO_BIT 0
`define EBW_CNT_HI_BIT 1
`define EBW_MODE_LO_BIT 2
`define EBW_MODE_HI_BIT 3
`define EBW_ACCESS_SEL_BIT 4
`define EBW_CTRL_W 5
`define EBW_CTRL_RST 5'h13

// ==========================================
// Pause mode codes
`define EBW_MODE_PROG 2'h0
`define EBW_MODE_OFF 2'h1
`define EBW_MODE_PIN 2'h2
`define EBW_MODE_AUTO 2'h3

// ==========================================
// AHB-Lite codes
`define EBW_HSIZE_BYTE 3'h0
`define EBW_HSIZE_HALF 3'h1
`define EBW_HRESP_OKAY 1'b0

`endif

// File: rtl/ebw_pause_gen.v
// Wait-state decision for one byte cycle of the external bus.
// Assumes the caller runs the bus states and holds mode and count stable.
`timescale 1ns/100ps
`include "ebw_consts.vh"

module ebw_pause_gen
(
    in_second,
    in_stall,
    pause_mode,
    pause_count,
    left_cur,
    stall_request_n,
    go_stall,
    left_next
);
    input wire in_second;
    input wire in_stall;
    input wire [1:0] pause_mode;
    input wire [1:0] pause_count;
    input wire [1:0] left_cur;
    input wire stall_request_n;
    output reg go_stall;
    output reg [1:0] left_next;

    // ==========================================
    // Decision at the end of the second state or of a stall state
    always @*
    begin
        go_stall = 1'b0;
        left_next = 2'h0;
        if (in_second)
        begin
            case (pause_mode)
                `EBW_MODE_PROG:
                begin
                    go_stall = (pause_count != 2'h0); // [R8] [R14]
                    left_next = pause_count - 2'h1;
                end
                `EBW_MODE_PIN:
                begin
                    if (pause_count != 2'h0)
                    begin
                        go_stall = 1'b1; // [R9]
                        left_next = pause_count - 2'h1;
                    end
                    else
                    begin
                        // Count of zero: pin is seen at the second state itself
                        go_stall = ~stall_request_n; // [R9]
                    end
                end
                `EBW_MODE_AUTO:
                begin
                    go_stall = ~stall_request_n & (pause_count != 2'h0); // [R11]
                    left_next = pause_count - 2'h1;
                end
                default:
                begin
                    go_stall = 1'b0; // [R13]
                end
            endcase
        end
        else if (in_stall)
        begin
            if (left_cur != 2'h0)
            begin
                go_stall = 1'b1; // [R8]
                left_next = left_cur - 2'h1;
            end
            else
            begin
                // Only pin mode extends past the count; auto-wait stops here
                go_stall = (pause_mode == `EBW_MODE_PIN) & ~stall_request_n; // [R10] [R11]
            end
        end
    end
endmodule

// File: rtl/ebw_ctrl.v
// External 8-bit bus controller with wait control, reached over AHB-Lite.
// Assumes one AHB-Lite master, inputs synchronous to hclk, one bus state
// per hclk cycle.
//
// What this block does
// [R1] Every external access moves one byte per bus cycle on the single 8-bit data lane.
// [R2] Word accesses become two and longword accesses four consecutive byte cycles.
// [R3] Read cycles assert the active-low read strobe while the lane is sampled.
// [R4] Write cycles assert only the upper store strobe; there is no lower one.
// [R5] No lower data lane exists, so nothing is driven or sampled there.
// [R6] With 2-state access every cycle ends after two states with no wait.
// [R7] With 3-state access cycles take three states plus waits of the chosen mode.
// [R8] Program wait mode inserts exactly the pause count between second and third state.
// [R9] Pin wait mode inserts the count, then samples the stall pin in the last state.
// [R10] In pin wait mode waits continue while the stall pin stays low.
// [R11] Pin auto-wait inserts the count only if the pin is low at the second state.
// [R12] Reset selects 3-state access, three waits and ignores the stall pin.
// [R13] Pause mode codes: 00 program, 01 disabled, 10 pin, 11 auto, in 3-state only.
// [R14] Pause count code n inserts n program waits, zero to three.
// [R15] 2-state access disables waits whatever mode and count say.
// [R16] Split accesses go to ascending addresses, most significant byte first.
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "ebw_consts.vh"

module ebw_ctrl
(
    hclk,
    hresetn,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hreadyout,
    hresp,
    hrdata,
    ext_addr,
    ext_data_in,
    ext_data_out,
    ext_data_oe,
    read_strobe_n,
    upper_store_strobe_n,
    stall_request_n
);
    input wire hclk;
    input wire hresetn;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output wire hreadyout;
    output wire hresp;
    output wire [31:0] hrdata;
    output wire [15:0] ext_addr;
    input wire [7:0] ext_data_in;
    output wire [7:0] ext_data_out;
    output wire ext_data_oe;
    output wire read_strobe_n;
    output wire upper_store_strobe_n;
    input wire stall_request_n;

    localparam S_IDLE = 5'b00001;
    localparam S_FIRST = 5'b00010;
    localparam S_SECOND = 5'b00100;
    localparam S_STALL = 5'b01000;
    localparam S_THIRD = 5'b10000;

    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [`EBW_CTRL_W-1:0] ctrl_reg;
    reg write_pend_reg;
    reg dir_write_reg;
    reg [1:0] byte_idx_reg;
    reg [1:0] last_idx_reg;
    reg [15:0] addr_reg;
    reg [31:0] wdata_reg;
    reg [31:0] rshift_reg;
    reg [31:0] hrdata_reg;
    reg [7:0] dout_reg;
    reg [1:0] left_reg;
    reg [7:0] wait_run_reg;
    reg [7:0] wait_last_reg;

    wire take;
    wire take_ext;
    wire take_reg;
    wire access_state_select;
    wire [1:0] pause_mode;
    wire [1:0] pause_count;
    wire go_stall;
    wire [1:0] left_next;
    wire byte_end;
    wire last_byte;
    wire [31:0] wsrc;
    wire [1:0] lane_sel;
    wire [31:0] rword;

    // ==========================================
    // Control field views
    assign access_state_select = ctrl_reg[`EBW_ACCESS_SEL_BIT];
    assign pause_mode = {ctrl_reg[`EBW_MODE_HI_BIT], ctrl_reg[`EBW_MODE_LO_BIT]};
    assign pause_count = {ctrl_reg[`EBW_CNT_HI_BIT], ctrl_reg[`EBW_CNT_LO_BIT]};

    // ==========================================
    // AHB-Lite address phase decode
    assign take = hsel & htrans[1] & hready;
    assign take_ext = take & haddr[`EBW_EXT_SEL_BIT];
    assign take_reg = take & ~haddr[`EBW_EXT_SEL_BIT];

    // Ready only while the external engine is idle
    assign hreadyout = state_reg[0];
    assign hresp = `EBW_HRESP_OKAY;
    assign hrdata = hrdata_reg;

    // ==========================================
    // Wait decision
    ebw_pause_gen u_pause
    (
        .in_second (state_reg[2] & access_state_select), // [R15]
        .in_stall (state_reg[3]),
        .pause_mode (pause_mode),
        .pause_count (pause_count),
        .left_cur (left_reg),
        .stall_request_n (stall_request_n),
        .go_stall (go_stall),
        .left_next (left_next)
    );

    // ==========================================
    // Bus state sequencing
    // Last state of a byte: second state in 2-state, third state otherwise
    assign byte_end = (state_reg[2] & ~access_state_select) | state_reg[4]; // [R6] [R7]
    assign last_byte = (byte_idx_reg == last_idx_reg);

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:
            begin
                if (take_ext)
                begin
                    state_next = S_FIRST;
                end
            end
            S_FIRST:
            begin
                state_next = S_SECOND;
            end
            S_SECOND:
            begin
                if (~access_state_select)
                begin
                    state_next = last_byte ? S_IDLE : S_FIRST; // [R6] [R15]
                end
                else if (go_stall)
                begin
                    state_next = S_STALL; // [R8]
                end
                else
                begin
                    state_next = S_THIRD; // [R7]
                end
            end
            S_STALL:
            begin
                state_next = go_stall ? S_STALL : S_THIRD; // [R9] [R10]
            end
            S_THIRD:
            begin
                state_next = last_byte ? S_IDLE : S_FIRST; // [R2]
            end
            default:
            begin
                state_next = S_IDLE;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= S_IDLE;
            left_reg <= 2'h0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg[2] | state_reg[3])
            begin
                left_reg <= left_next;
            end
        end
    end

    // ==========================================
    // Byte splitting and address stepping
    // Data is right-aligned in the word; the top byte of the unit goes first
    assign wsrc = (state_reg[1] & (byte_idx_reg == 2'h0)) ? hwdata : wdata_reg;
    assign lane_sel = last_idx_reg - byte_idx_reg; // [R16]
    assign rword = {rshift_reg[23:0], ext_data_in}; // [R1]

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dir_write_reg <= 1'b0;
            byte_idx_reg <= 2'h0;
            last_idx_reg <= 2'h0;
            addr_reg <= 16'h0000;
            wdata_reg <= 32'h0000_0000;
            rshift_reg <= 32'h0000_0000;
            dout_reg <= 8'h00;
        end
        else
        begin
            if (state_reg[0] & take_ext)
            begin
                dir_write_reg <= hwrite;
                byte_idx_reg <= 2'h0;
                addr_reg <= haddr[`EBW_EXT_AW-1:0];
                rshift_reg <= 32'h0000_0000;
                if (hsize == `EBW_HSIZE_BYTE)
                begin
                    last_idx_reg <= 2'h0;
                end
                else if (hsize == `EBW_HSIZE_HALF)
                begin
                    last_idx_reg <= 2'h1; // [R2]
                end
                else
                begin
                    last_idx_reg <= 2'h3; // [R2]
                end
            end
            if (state_reg[1])
            begin
                // Write data is only on hwdata in the data phase; keep a copy
                if (byte_idx_reg == 2'h0)
                begin
                    wdata_reg <= hwdata;
                end
                case (lane_sel)
                    2'h0: dout_reg <= wsrc[7:0]; // [R1]
                    2'h1: dout_reg <= wsrc[15:8];
                    2'h2: dout_reg <= wsrc[23:16];
                    default: dout_reg <= wsrc[31:24];
                endcase
            end
            if (byte_end)
            begin
                if (~dir_write_reg)
                begin
                    rshift_reg <= rword; // [R3]
                end
                if (~last_byte)
                begin
                    byte_idx_reg <= byte_idx_reg + 2'h1;
                    addr_reg <= addr_reg + 16'h0001; // [R16]
                end
            end
        end
    end

    // ==========================================
    // External pins
    // Strobes decode flop state directly; each change of state moves two one-hot state bits at once
    assign ext_addr = addr_reg;
    assign ext_data_out = dout_reg; // [R5]
    assign ext_data_oe = dir_write_reg & (state_reg[2] | state_reg[3] | state_reg[4]);
    assign read_strobe_n = ~(~dir_write_reg & ~state_reg[0]); // [R3]
    assign upper_store_strobe_n = ~(dir_write_reg &
        (state_reg[2] | state_reg[3] | state_reg[4])); // [R4]

    // ==========================================
    // Wait statistics for software
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wait_run_reg <= 8'h00;
            wait_last_reg <= 8'h00;
        end
        else
        begin
            if (state_reg[0] & take_ext)
            begin
                wait_run_reg <= 8'h00;
            end
            else if (state_reg[3] & (wait_run_reg != 8'hff))
            begin
                wait_run_reg <= wait_run_reg + 8'h01;
            end
            if (byte_end & last_byte)
            begin
                wait_last_reg <= wait_run_reg;
            end
        end
    end

    // ==========================================
    // Register window and read data
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_reg <= `EBW_CTRL_RST; // [R12]
            write_pend_reg <= 1'b0;
            hrdata_reg <= 32'h0000_0000;
        end
        else
        begin
            write_pend_reg <= take_reg & hwrite &
                (haddr[11:0] == `EBW_OFS_CTRL) & (haddr[31:12] == 20'h0_0000);
            if (write_pend_reg)
            begin
                ctrl_reg <= hwdata[`EBW_CTRL_W-1:0]; // [R13] [R14]
            end
            if (byte_end & last_byte)
            begin
                hrdata_reg <= dir_write_reg ? 32'h0000_0000 : rword; // [R2]
            end
            else if (take_reg & ~hwrite)
            begin
                if (haddr[31:12] != 20'h0_0000)
                begin
                    hrdata_reg <= 32'h0000_0000;
                end
                else if (haddr[11:0] == `EBW_OFS_CTRL)
                begin
                    hrdata_reg <= {27'h000_0000, ctrl_reg};
                end
                else if (haddr[11:0] == `EBW_OFS_STAT)
                begin
                    hrdata_reg <= {24'h00_0000, wait_last_reg};
                end
                else
                begin
                    hrdata_reg <= 32'h0000_0000;
                end
            end
        end
    end
endmodule

// File: verif/ebw_ctrl_properties.sv
// Port checker for the external byte-bus controller.
// Assumes binding to ebw_ctrl; keeps its own copy of the control register.
`timescale 1ns/100ps
`include "ebw_consts.vh"
module ebw_ctrl_chk(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire [15:0] ext_addr,
    input wire [7:0] ext_data_out,
    input wire ext_data_oe,
    input wire read_strobe_n,
    input wire upper_store_strobe_n
);
    logic pend;
    logic [4:0] ctrl;
    logic [7:0] lo_cnt;
    // ==========================================
    // Shadow control and store strobe length
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend <= 1'b0;
            ctrl <= `EBW_CTRL_RST;
            lo_cnt <= 8'h00;
        end
        else
        begin
            pend <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0000_0000;
            if (pend)
                ctrl <= hwdata[4:0];
            lo_cnt <= upper_store_strobe_n ? 8'h00 : lo_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_IDLE_QUIET:
        assert property (hreadyout |-> read_strobe_n && upper_store_strobe_n && !ext_data_oe)
        else $error("strobe active while idle");
    AST_STROBE_EXCL:
        assert property (!read_strobe_n |-> upper_store_strobe_n && !ext_data_oe)
        else $error("read and write strobes together");
    AST_OE_STROBE:
        assert property (ext_data_oe == !upper_store_strobe_n)
        else $error("lane drive not matched to store strobe");
    AST_WDATA_STABLE:
        assert property (!upper_store_strobe_n && !$past(upper_store_strobe_n)
            |-> $stable(ext_data_out) && $stable(ext_addr))
        else $error("write byte moved inside cycle");
    AST_TWO_STATE:
        assert property ($rose(upper_store_strobe_n) && !ctrl[4] |-> lo_cnt == 8'h01)
        else $error("two-state write stretched");
    AST_PROG_WAIT:
        assert property ($rose(upper_store_strobe_n) && ctrl[4] && !ctrl[3]
            |-> lo_cnt == (ctrl[2] ? 8'h02 : 8'h02 + ctrl[1:0]))
        else $error("program wait count wrong");
    AST_AUTO_MAX:
        assert property ($rose(upper_store_strobe_n) && ctrl[4] && ctrl[3:2] == 2'h3
            |-> lo_cnt == 8'h02 || lo_cnt == 8'h02 + ctrl[1:0])
        else $error("auto wait count wrong");
    AST_PIN_MIN:
        assert property ($rose(upper_store_strobe_n) && ctrl[4] && ctrl[3:2] == 2'h2
            |-> lo_cnt >= 8'h02 + ctrl[1:0])
        else $error("pin wait too short");
    cover property ($rose(upper_store_strobe_n) && !ctrl[4]);
    cover property ($rose(upper_store_strobe_n) && ctrl[3:2] == 2'h2 && lo_cnt > 8'h05);
    cover property ($rose(upper_store_strobe_n) && ctrl[3:2] == 2'h3 && lo_cnt > 8'h02);
endmodule
bind ebw_ctrl ebw_ctrl_chk i_ebw_ctrl_chk(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .ext_addr, .ext_data_out, .ext_data_oe, .read_strobe_n,
    .upper_store_strobe_n);

// File: verif/ebw_ext_mem.sv
// Byte-wide external memory with a stall pin.
// Assumes only ext_addr[7:0] is decoded; slow sets the stall length.
`timescale 1ns/100ps
module ebw_ext_mem(
    input logic hclk,
    input logic read_strobe_n,
    input logic upper_store_strobe_n,
    input logic [15:0] ext_addr,
    input logic [7:0] ext_data_out,
    input logic ext_data_oe,
    input logic [4:0] slow,
    output logic [7:0] ext_data_in,
    output logic stall_request_n
);
    logic [7:0] mem [0:255];
    logic [7:0] last = 8'h00;
    logic [4:0] busy = 5'h00;
    logic [15:0] prev = 16'h0000;
    wire act = !(read_strobe_n && upper_store_strobe_n);
    // ==========================================
    // Stall held low for the first slow cycles of each byte
    assign stall_request_n = !(act && busy < slow);
    // Released lane shows inverted data so stale bytes never match
    assign ext_data_in = read_strobe_n ? ~last : mem[ext_addr[7:0]];
    always @(posedge hclk)
    begin
        prev <= ext_addr;
        busy <= !act ? 5'h00 : (ext_addr != prev) ? 5'h01 : busy + {4'h0, busy != 5'h1f};
        if (!read_strobe_n)
            last <= mem[ext_addr[7:0]];
        if (!upper_store_strobe_n && ext_data_oe)
            mem[ext_addr[7:0]] <= ext_data_out;
    end
endmodule

// File: verif/tb_top.sv
// Self-checking bench for ebw_ctrl over AHB-Lite.
// Assumes a single slave, so hready follows hreadyout.
`timescale 1ns/100ps
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [4:0] slow = 5'h00;
    logic [31:0] seed = 32'h0bda_5f0e;
    logic [4:0] corner [8] = '{5'h0b, 5'h1b, 5'h1f, 5'h17, 5'h0f, 5'h13, 5'h1c, 5'h10};
    wire hreadyout, hresp, ext_data_oe, read_strobe_n, upper_store_strobe_n, stall_request_n;
    wire [31:0] hrdata;
    wire [15:0] ext_addr;
    wire [7:0] ext_data_in, ext_data_out;
    int fails = 0;
    int n_compared = 0;
    always #5 hclk = ~hclk;
    ebw_ctrl i_ebw_ctrl(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_addr, .ext_data_in,
        .ext_data_out, .ext_data_oe, .read_strobe_n, .upper_store_strobe_n, .stall_request_n);
    ebw_ext_mem i_ebw_ext_mem(.hclk, .read_strobe_n, .upper_store_strobe_n, .ext_addr,
        .ext_data_out, .ext_data_oe, .slow, .ext_data_in, .stall_request_n);
    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Waits per write byte; the model holds the stall pin for slow cycles of the byte
    function automatic int ew(logic [4:0] c, logic [4:0] s);
        if (!c[4] || c[3:2] == 2'h1) return 0;
        if (c[3:2] == 2'h0) return c[1:0];
        if (c[3:2] == 2'h3) return (s != 5'h00) ? c[1:0] : 0;
        return (s > {3'h0, c[1:0]}) ? s : c[1:0];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Sampled at the falling edge: flops settle there and hold to the next rise
    // No limit here: only the watchdog ends a wait
    task automatic wrdy();
        do
        begin
            @(negedge hclk);
        end
        while (hreadyout !== 1'b1);
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [2:0] s,
        input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= s;
        htrans <= 2'h2;
        wrdy();
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wrdy();
        r = hrdata;
        @(posedge hclk);
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        logic [31:0] r, d, a, wd;
        logic [4:0] c, sl;
        logic [2:0] s;
        int nb, w;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h0000_0000, 3'h2, 32'h0000_0000, r);
        chk(r, 32'h0000_0013, "ctrl reset");
        ahb(1'b1, 32'h0000_0004, 3'h2, 32'h0000_00ff, r);
        ahb(1'b0, 32'h0000_0004, 3'h2, 32'h0000_0000, r);
        chk(r, 32'h0000_0000, "stat read only");
        ahb(1'b0, 32'h0000_0008, 3'h2, 32'h0000_0000, r);
        chk(r, 32'h0000_0000, "unmapped");
        ahb(1'b1, 32'h0000_1000, 3'h2, 32'h0000_0000, r);
        ahb(1'b0, 32'h0000_1000, 3'h2, 32'h0000_0000, r);
        chk(r, 32'h0000_0000, "high window");
        ahb(1'b0, 32'h0000_0000, 3'h2, 32'h0000_0000, r);
        chk(r, 32'h0000_0013, "ctrl kept");
        $display("test registers done");
        for (int i = 0; i < 40; i++)
        begin
            d = rnd();
            c = (i < 8) ? corner[i] : d[20:16];
            sl = (i < 4 || d[8]) ? 5'h0f : 5'h00;
            slow <= sl;
            s = (d[1:0] == 2'h3) ? 3'h2 : {1'b0, d[1:0]};
            nb = 1 << s;
            a = {16'h0001, 8'h00, d[15:10], 2'h0};
            wd = rnd() >> (32 - 8 * nb);
            ahb(1'b1, 32'h0000_0000, 3'h2, {27'h0, c}, r);
            ahb(1'b1, a, s, wd, r);
            ahb(1'b0, 32'h0000_0004, 3'h2, 32'h0000_0000, r);
            w = ew(c, sl);
            if (c[4] && c[3:2] == 2'h2 && sl != 5'h00)
                chk(r, w * nb, "pin stretch");
            else
                chk(r, w * nb, "wait count");
            ahb(1'b0, a, s, 32'h0000_0000, r);
            chk(r, wd, "read back");
            ahb(1'b0, a, 3'h0, 32'h0000_0000, r);
            chk(r, wd >> (8 * nb - 8), "first byte");
        end
        $display("test random transfers done");
        end_sim();
    end
    initial
    begin
        // About six times the longest expected run
        #400_000;
        fails++;
        end_sim();
    end
endmodule
